/* File: logic/bpr_route_ctrl.sv */
// Bias port routing core with a classic Wishbone register slave
`timescale 1ns/1ps
module bpr_route_ctrl import bpr_pkg::*; #(
  parameter int NUM_CARD = 4,
  parameter int NUM_OUT  = 12,
  parameter int NUM_IN   = 10
) (
  // Clock, reset, enable
  input  wire logic                         CLK_SYS,
  input  wire logic                         RESET_N,
  input  wire logic                         CE,
  // Wishbone slave
  input  wire logic                         WB_CYC_I,
  input  wire logic                         WB_STB_I,
  input  wire logic                         WB_WE_I,
  input  wire logic [7:0]                   WB_ADR_I,
  input  wire logic [3:0]                   WB_SEL_I,
  input  wire logic [31:0]                  WB_DAT_I,
  output      logic [31:0]                  WB_DAT_O,
  output      logic                         WB_ACK_O,
  // Relay side
  input  wire logic [NUM_CARD*NUM_OUT-1:0]  OTHER_CONN_I,
  output      logic [NUM_CARD*NUM_OUT-1:0]  BIAS_RELAY_O,
  output      logic [NUM_CARD*4-1:0]        BIAS_PORT_O,
  output      logic [NUM_CARD-1:0]          BIAS_MODE_O
);

  if (NUM_CARD < 1 || NUM_CARD > 4) $error("NUM_CARD must be 1 to 4");
  if (NUM_OUT < 1 || NUM_OUT > 12) $error("NUM_OUT must be 1 to 12");
  if (NUM_IN < 1 || NUM_IN > 15) $error("NUM_IN must be 1 to 15");

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  // ==========================================================
  // State
  logic                             ack_ff;
  logic [31:0]                      dat_ff;
  logic [31:0]                      cmd_ff;
  logic                             go_ff;
  logic                             err_ff;
  bpr_cfg_t                         cfg_ff;
  logic [NUM_CARD-1:0][NUM_OUT-1:0] bias_en_ff;
  logic [NUM_CARD-1:0][NUM_OUT-1:0] relay_ff;
  logic [NUM_CARD-1:0]              mode_ff;
  logic [NUM_CARD-1:0][3:0]         port_ff;
  bpr_rule_t                        rule_ff [NUM_CARD];
  bpr_seq_t                         seq_ff [NUM_CARD];
  logic [31:0]                      res_ff;
  logic [5:0]                       cnt_ff;

  logic [NUM_CARD-1:0][NUM_OUT-1:0] nxt_en;
  logic [NUM_CARD-1:0]              nxt_mode;
  logic                             wb_hit;
  logic                             wr;
  logic                             act;
  logic [7:0]                       card_off;
  logic [1:0]                       q_card;
  logic                             q_bit;
  logic [4:0]                       q_idx;

  bpr_cmd_if #(.NUM_CARD(NUM_CARD)) cmd ();

  bpr_cmd_decode #(.NUM_CARD(NUM_CARD), .NUM_OUT(NUM_OUT), .NUM_IN(NUM_IN)) u_dec (
    .go_in  (go_ff),
    .cmd_in (cmd_ff),
    .cfg_in (cfg_ff),
    .cmd    (cmd)
  );

  // ==========================================================
  // Wishbone slave
  // Ack comes one edge after the request; unmapped reads give zero
  assign wb_hit   = WB_CYC_I && WB_STB_I && !ack_ff;
  assign wr       = wb_hit && WB_WE_I;
  assign card_off = WB_ADR_I - ADR_CARD0;
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_ff <= 1'b0;
    end else if (CE) begin
      ack_ff <= wb_hit;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      dat_ff <= 32'h0;
    end else if (CE && wb_hit && !WB_WE_I) begin
      dat_ff <= 32'h0;
      if (WB_ADR_I == ADR_CMD) dat_ff <= cmd_ff;
      else if (WB_ADR_I == ADR_STAT) begin
        dat_ff[STAT_ERR_BIT]             <= err_ff;
        dat_ff[STAT_CFG_BIT]             <= cfg_ff;
        dat_ff[STAT_CNT_LSB +: 6]        <= cnt_ff;
        dat_ff[STAT_MODE_LSB +: NUM_CARD] <= mode_ff;
      end else if (WB_ADR_I == ADR_RES) dat_ff <= res_ff;
      else if (WB_ADR_I >= ADR_CARD0 && card_off[1:0] == 2'h0 &&
               card_off[7:2] < 6'(NUM_CARD)) begin
        dat_ff[CW_EN_LSB +: 12]    <= 12'(bias_en_ff[card_off[3:2]]);
        dat_ff[CW_RELAY_LSB +: 12] <= 12'(relay_ff[card_off[3:2]]);
        dat_ff[CW_PORT_LSB +: 4]   <= port_ff[card_off[3:2]];
        dat_ff[CW_MODE_BIT]        <= mode_ff[card_off[3:2]];
        dat_ff[CW_RULE_BIT]        <= rule_ff[card_off[3:2]];
        dat_ff[CW_SEQ_LSB +: 2]    <= seq_ff[card_off[3:2]];
      end
    end
  end

  // Command register; a write with byte selects 0 to 2 all set launches one command the next cycle
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      cmd_ff <= 32'h0;
      go_ff  <= 1'b0;
    end else if (CE) begin
      go_ff <= 1'b0;
      if (wr && WB_ADR_I == ADR_CMD && &WB_SEL_I[2:0]) begin
        cmd_ff <= WB_DAT_I;
        go_ff  <= 1'b1;
      end
    end
  end

  a_ack_pulse: assert property (ack_ff |=> !ack_ff)
    else $error("ack held longer than one cycle");

  // ==========================================================
  // Error flag: a new fault wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      err_ff <= 1'b0;
    end else if (CE) begin
      if (go_ff && (cmd.bad || (cmd.op == OP_QRY_DIS && cnt_ff == QRY_DEPTH))) begin
        err_ff <= 1'b1; // RQ12
      end else if (wr && WB_ADR_I == ADR_STAT && WB_SEL_I[0] && WB_DAT_I[STAT_ERR_BIT]) begin
        err_ff <= 1'b0;
      end
    end
  end

  a_bad_card: assert property (CE && cmd.go && cmd.bad |=> err_ff && $stable(bias_en_ff)) // RQ12
    else $error("refused command changed state or left no error");

  // ==========================================================
  // Enable masks and bias mode
  assign act = go_ff && !cmd.bad;

  always_comb begin
    nxt_en   = bias_en_ff;
    nxt_mode = mode_ff;
    if (act && cmd.op == OP_RESET) begin
      nxt_en   = '1; // RQ5
      nxt_mode = '0; // RQ14
    end else if (act) begin
      for (int c = 0; c < NUM_CARD; c++) begin
        if (cmd.cards[c]) begin
          unique case (cmd.op)
            OP_DIS_CARD:  nxt_en[c] = '0; // RQ3
            OP_DIS_LIST:  nxt_en[c][cmd.outi] = 1'b0; // RQ6
            OP_EN_CARD:   nxt_en[c] = '1; // RQ11
            OP_EN_LIST:   nxt_en[c][cmd.outi] = 1'b1;
            OP_BIAS_MODE: nxt_mode[c] = cmd.val[0];
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      bias_en_ff <= '1; // RQ5
      mode_ff    <= '0; // RQ14
    end else if (CE) begin
      bias_en_ff <= nxt_en;
      mode_ff    <= nxt_mode;
    end
  end

  // ==========================================================
  // Bias relays
  // Relays follow the mask only in bias mode; otherwise they are left
  // alone, except that instrument reset opens them, so that direct routing owns them
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      relay_ff <= '0;
    end else if (CE) begin
      for (int c = 0; c < NUM_CARD; c++) begin
        if (nxt_mode[c]) begin // RQ16 RQ6 RQ11
          // Closed on enabled free outputs, opened elsewhere
          relay_ff[c] <= nxt_en[c] & ~OTHER_CONN_I[c*NUM_OUT +: NUM_OUT]; // RQ13 RQ1 RQ2 RQ4
        end else if (act && cmd.op == OP_RESET) begin
          relay_ff[c] <= '0; // RQ1
        end
      end
    end
  end

  assign BIAS_RELAY_O = relay_ff;
  assign BIAS_PORT_O  = port_ff;
  assign BIAS_MODE_O  = mode_ff;

  sequence s_cmd(bpr_op_t o);
    CE && cmd.go && !cmd.bad && cmd.op == o && cmd.cards[0];
  endsequence

  sequence s_all_open;
    relay_ff[0] == '0;
  endsequence

  a_rst_state: assert property (CE && act && cmd.op == OP_RESET |=>
      bias_en_ff == '1 && mode_ff == '0 && relay_ff == '0) // RQ5 RQ14
    else $error("instrument reset left a port disabled or bias mode on");

  a_card_disable: assert property (s_cmd(OP_DIS_CARD) |=> bias_en_ff[0] == '0) // RQ3
    else $error("card disable left an enable flag set");

  a_card_dis_relay: assert property (s_cmd(OP_DIS_CARD) ##0 mode_ff[0] |=> s_all_open) // RQ4
    else $error("card disable in bias mode left a relay closed");

  a_list_disable: assert property (s_cmd(OP_DIS_LIST) ##0 mode_ff[0] |=>
      !bias_en_ff[0][$past(cmd.outi)] && !relay_ff[0][$past(cmd.outi)] &&
      $countones(bias_en_ff[0]) >= $countones($past(bias_en_ff[0])) - 1) // RQ6
    else $error("list disable wrong in bias mode");

  a_card_enable: assert property (s_cmd(OP_EN_CARD) ##0 mode_ff[0] |=>
      relay_ff[0] == ~$past(OTHER_CONN_I[NUM_OUT-1:0])) // RQ11 RQ2
    else $error("card enable did not close free bias relays");

  a_mode_off_hold: assert property (s_cmd(OP_EN_CARD) ##0 !mode_ff[0] |=>
      $stable(relay_ff[0])) // RQ16
    else $error("enable with bias mode off moved a relay");

  a_bias_track: assert property (CE && mode_ff[0] && !go_ff ##1 CE && !go_ff |->
      relay_ff[0] == (bias_en_ff[0] & ~$past(OTHER_CONN_I[NUM_OUT-1:0]))) // RQ13
    else $error("bias relays not following enabled free outputs");

  a_ce_freeze: assert property (!CE |=> $stable(relay_ff) && $stable(bias_en_ff) &&
      $stable(mode_ff) && $stable(port_ff))
    else $error("state moved while the clock enable was low");

  // ==========================================================
  // Per-card bias port, rule, sequence; global config
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      port_ff <= {NUM_CARD{RST_BIAS_PORT}};
      rule_ff <= '{default: free_rule};
      seq_ff  <= '{default: no_sequence};
    end else if (CE && act) begin
      for (int c = 0; c < NUM_CARD; c++) begin
        if (cmd.op == OP_RESET) begin
          port_ff[c] <= RST_BIAS_PORT;
          rule_ff[c] <= free_rule;
          seq_ff[c]  <= no_sequence;
        end else if (cmd.cards[c]) begin
          if (cmd.op == OP_BIAS_PORT) port_ff[c] <= cmd.val; // RQ15
          if (cmd.op == OP_RULE) rule_ff[c] <= bpr_rule_t'(cmd.val[0]); // RQ17
          if (cmd.op == OP_SEQ) seq_ff[c] <= bpr_seq_t'(cmd.val[1:0]); // RQ17
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_ff <= normal_config_select;
    end else if (CE && act && cmd.op == OP_CONFIG) begin
      cfg_ff <= bpr_cfg_t'(cmd.val[0]); // RQ17
    end
  end

  // ==========================================================
  // Disable status query: one bit per entry, packed in request order
  always_comb begin
    q_card = 2'h0;
    for (int c = NUM_CARD - 1; c >= 0; c--) begin
      if (cmd.cards[c]) q_card = 2'(c);
    end
  end

  assign q_bit = ~bias_en_ff[q_card][cmd.outi]; // RQ9
  assign q_idx = cnt_ff[4:0];

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      res_ff <= 32'h0;
      cnt_ff <= 6'h0;
    end else if (CE && act) begin
      if (cmd.op == OP_QRY_CLR) begin
        res_ff <= 32'h0;
        cnt_ff <= 6'h0;
      end else if (cmd.op == OP_QRY_DIS && cnt_ff != QRY_DEPTH) begin
        res_ff[q_idx] <= q_bit; // RQ9 RQ10
        cnt_ff        <= cnt_ff + 6'h1; // RQ10
      end
    end
  end

  a_query_bit: assert property (s_cmd(OP_QRY_DIS) ##0 cnt_ff != QRY_DEPTH |=>
      res_ff[$past(q_idx)] == !$past(bias_en_ff[0][cmd.outi]) &&
      cnt_ff == $past(cnt_ff) + 6'h1) // RQ9 RQ10
    else $error("query answer not appended in order");

endmodule

/* File: logic/bpr_pkg.sv */
// Constants, command layout and types for bias port route control
// ==========================================================
// Notes on behaviour
// RQ1: Opening a channel drives its relays open, disconnecting input from output.
// RQ2: Closing a channel drives its relays closed, connecting input to output.
// RQ3: Card-wide bias disable clears every output enable flag of the addressed card.
// RQ4: With bias mode on, card-wide disable also opens all bias relays of that card.
// RQ5: After instrument reset every output of every card is bias enabled.
// RQ6: List disable clears only listed flags; with bias mode on opens their relays.
// RQ7: Bias channel entries ignore the input field; input is always the bias port.
// RQ8: Host still supplies an input field in every bias channel entry.
// RQ9: Disable status query answers 1 for disabled, 0 for enabled output.
// RQ10: Query answers come back in the order the channels were requested.
// RQ11: Card-wide enable with bias mode on closes bias relays of unconnected outputs.
// RQ12: Card selector: 0 or ALL in auto config, 1 to 4 or ALL in normal.
// RQ13: Bias mode on keeps bias port tied to enabled, otherwise unconnected outputs.
// RQ14: After instrument reset bias mode is off on every card.
// RQ15: Bias port is input 1 to 10, held separately for each card.
// RQ16: Enable or disable with bias mode off only updates masks, relays unchanged.
// RQ17: Decode config auto/normal, rule free/single, sequence none/bbm/mbb, per card.
package bpr_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] ADR_CMD   = 8'h00;
  localparam logic [7:0] ADR_STAT  = 8'h04;
  localparam logic [7:0] ADR_RES   = 8'h08;
  localparam logic [7:0] ADR_CARD0 = 8'h10;

  // ==========================================================
  // Command word fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_CARD_LSB = 4;
  localparam int CMD_OUT_LSB  = 8;
  localparam int CMD_IN_LSB   = 12;
  localparam int CMD_VAL_LSB  = 16;
  localparam logic [2:0] CARD_ALL = 3'h7;

  // ==========================================================
  // Status word fields
  localparam int STAT_ERR_BIT  = 0;
  localparam int STAT_CFG_BIT  = 1;
  localparam int STAT_CNT_LSB  = 2;
  localparam int STAT_MODE_LSB = 8;

  // ==========================================================
  // Card word fields
  localparam int CW_EN_LSB    = 0;
  localparam int CW_RELAY_LSB = 12;
  localparam int CW_PORT_LSB  = 24;
  localparam int CW_MODE_BIT  = 28;
  localparam int CW_RULE_BIT  = 29;
  localparam int CW_SEQ_LSB   = 30;

  // ==========================================================
  // Reset values and limits
  localparam logic [3:0] RST_BIAS_PORT = 4'hA;
  localparam logic [5:0] QRY_DEPTH     = 6'h20;

  typedef enum logic [3:0] {
    OP_NOP, OP_DIS_CARD, OP_DIS_LIST, OP_EN_CARD, OP_EN_LIST, OP_BIAS_MODE,
    OP_BIAS_PORT, OP_RULE, OP_SEQ, OP_CONFIG, OP_QRY_CLR, OP_QRY_DIS, OP_RESET
  } bpr_op_t;

  typedef enum logic {auto_config_select, normal_config_select} bpr_cfg_t;
  typedef enum logic {free_rule, single_route_rule} bpr_rule_t;
  typedef enum logic [1:0] {
    no_sequence, break_before_make_seq, make_before_break_seq
  } bpr_seq_t;

endpackage

/* File: logic/bpr_cmd_if.sv */
// Decoded command carried from the decoder to the routing core
`timescale 1ns/1ps
interface bpr_cmd_if #(parameter int NUM_CARD = 4);
  import bpr_pkg::*;
  logic                go;
  logic                bad;
  bpr_op_t             op;
  logic [NUM_CARD-1:0] cards;
  logic [3:0]          outi;
  logic [3:0]          val;
  modport dec  (output go, bad, op, cards, outi, val);
  modport core (input go, bad, op, cards, outi, val);
endinterface

/* File: logic/bpr_cmd_decode.sv */
// Command word decoder: card selector, field checks, operand extraction
`timescale 1ns/1ps
module bpr_cmd_decode import bpr_pkg::*; #(
  parameter int NUM_CARD = 4,
  parameter int NUM_OUT  = 12,
  parameter int NUM_IN   = 10
) (
  // Command
  input wire logic  go_in,
  input wire logic  [31:0] cmd_in,
  input bpr_cfg_t   cfg_in,
  // Decoded
  bpr_cmd_if.dec    cmd
);

  function automatic logic [NUM_CARD-1:0] card_mask(input logic [2:0] sel,
                                                    input bpr_cfg_t cfg, input logic one);
    logic [NUM_CARD-1:0] m;
    m = '0;
    if (cfg == auto_config_select) begin
      if (sel == 3'h0) m = one ? NUM_CARD'(1) : '1; // RQ12
      else if (sel == CARD_ALL && !one) m = '1; // RQ12
    end else begin
      if (sel == CARD_ALL && !one) m = '1; // RQ12
      else if (sel >= 3'h1 && sel <= 3'(NUM_CARD)) m = NUM_CARD'(1) << (sel - 3'h1); // RQ12
    end
    return m;
  endfunction

  logic [3:0] op_raw;
  logic [3:0] outp;
  logic       one;
  logic       need_card;

  // The input-port field of a channel entry is never looked at
  always_comb begin
    op_raw    = cmd_in[CMD_OP_LSB +: 4];
    outp      = cmd_in[CMD_OUT_LSB +: 4]; // RQ7
    cmd.val   = cmd_in[CMD_VAL_LSB +: 4];
    cmd.op    = bpr_op_t'(op_raw);
    cmd.go    = go_in;
    cmd.outi  = outp - 4'h1;
    one       = (cmd.op == OP_QRY_DIS);
    need_card = !(cmd.op inside {OP_NOP, OP_CONFIG, OP_QRY_CLR, OP_RESET});
    cmd.cards = card_mask(cmd_in[CMD_CARD_LSB +: 3], cfg_in, one);
    cmd.bad   = 1'b0;
    if (op_raw > OP_RESET) cmd.bad = 1'b1;
    if (need_card && cmd.cards == '0) cmd.bad = 1'b1; // RQ12
    if (cmd.op inside {OP_DIS_LIST, OP_EN_LIST, OP_QRY_DIS} &&
        (outp == 4'h0 || outp > 4'(NUM_OUT))) cmd.bad = 1'b1;
    unique case (cmd.op)
      OP_BIAS_PORT: if (cmd.val == 4'h0 || cmd.val > 4'(NUM_IN)) cmd.bad = 1'b1; // RQ15
      OP_SEQ:       if (cmd.val > 4'h2) cmd.bad = 1'b1; // RQ17
      OP_BIAS_MODE, OP_RULE, OP_CONFIG: if (cmd.val > 4'h1) cmd.bad = 1'b1; // RQ17
      default: ;
    endcase
  end

endmodule

/* File: test/bpr_conn_model.sv */
// Model of the other routes on the cards: outputs held by non-bias inputs
`timescale 1ns/1ps
module bpr_conn_model #(
  parameter int W = 48
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Route set request
  input  wire logic         load,
  input  wire logic [W-1:0] pattern,
  // Connection state
  output      logic [W-1:0] conn
);
  // ==========================================================
  // Routes
  // Routes move only on a clock edge or when reset clears them, like a latched relay driver
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conn <= '0;
    end else if (load) begin
      conn <= pattern;
    end
  end
endmodule

/* File: test/tb_bpr_route_ctrl.sv */
// Testbench for the bias port route controller
`timescale 1ns/1ps
module tb_bpr_route_ctrl import bpr_pkg::*; ;
  typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} bpr_note_t;
  logic        clk_sys, reset_n, cyc, stb, we, ld, ack, ce;
  logic [7:0]  adr;
  logic [3:0]  sel, bmode;
  logic [31:0] dat_i, dat_o, seed;
  logic [47:0] oth, pat, conn, relay, e;
  logic [15:0] bport;
  int          errors, cmp_count;
  bpr_note_t   q[$];
  bpr_note_t   nt;

  bpr_conn_model u_bpr_conn_model (.clk(clk_sys), .rst_n(reset_n), .load(ld),
    .pattern(pat), .conn(conn));
  bpr_route_ctrl u_bpr_route_ctrl (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CE(ce),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .OTHER_CONN_I(conn),
    .BIAS_RELAY_O(relay), .BIAS_PORT_O(bport), .BIAS_MODE_O(bmode));

  // ==========================================================
  // Helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task results();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Classic cycle; the wait is bounded so a dead slave ends the run
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      errors++;
      results();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rd(input string nm, input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    q.push_back('{nm, x, m});
    wb(1'b0, a, 32'h0, 4'hF);
  endtask

  // Input field is random: the block must not look at it
  task cm(input bpr_op_t op, input logic [2:0] c, input logic [3:0] o, input logic [3:0] v);
    logic [31:0] r;
    r = rnd();
    wb(1'b1, ADR_CMD, {12'h0, v, r[3:0], o, 1'b0, c, op}, 4'hF);
  endtask

  task ldp();
    logic [63:0] t;
    t = {rnd(), rnd()};
    oth = t[47:0];
    pat <= t[47:0];
    ld <= 1'b1;
    @(posedge clk_sys);
    ld <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // ==========================================================
  // Read monitor: oldest note against each read answer
  always @(posedge clk_sys) begin
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
      nt = q.pop_front();
      chk(nt.nm, dat_o & nt.msk, nt.exp & nt.msk);
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    {cyc, stb, we, ld, adr, sel, dat_i, pat, oth} = '0;
    seed = 32'h95F89C68;
    ce = 1'b1;
    errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    for (int c = 0; c < 4; c++) rd("card", ADR_CARD0 + 8'(4 * c), 32'h0A000FFF, '1);
    rd("stat", ADR_STAT, 32'h2, '1);
    rd("unmapped", 8'h40, 32'h0, '1);
    chk("port", bport, 16'hAAAA);
    wb(1'b1, ADR_CMD, {12'h0, 4'h1, 4'h0, 4'h0, 1'b0, 3'h7, OP_BIAS_MODE}, 4'h3);
    repeat (3) @(posedge clk_sys);
    chk("mode sel", bmode, 4'h0);
    ldp();
    cm(OP_BIAS_MODE, 3'h7, 4'h0, 4'h1);
    repeat (3) @(posedge clk_sys);
    chk("mode", bmode, 4'hF);
    chk("relay on", relay, ~oth);
    cm(OP_DIS_LIST, 3'h2, 4'h3, 4'h0);
    cm(OP_DIS_LIST, 3'h3, 4'h5, 4'h0);
    repeat (3) @(posedge clk_sys);
    e = ~oth;
    e[14] = 1'b0;
    e[28] = 1'b0;
    chk("relay list", relay, e);
    rd("en list", ADR_CARD0 + 8'h4, 32'hFFB, 32'hFFF);
    cm(OP_DIS_CARD, 3'h1, 4'h0, 4'h0);
    repeat (3) @(posedge clk_sys);
    chk("relay dis card", relay[11:0], 12'h0);
    rd("en card", ADR_CARD0, 32'h0, 32'hFFF);
    cm(OP_EN_CARD, 3'h1, 4'h0, 4'h0);
    repeat (3) @(posedge clk_sys);
    chk("relay en card", relay[11:0], 12'(~oth[11:0]));
    ldp();
    chk("relay follow", relay[11:0], 12'(~oth[11:0]));
    // Clock enable low: routes move but relays must not follow
    e = relay;
    ce <= 1'b0;
    ldp();
    chk("relay frozen", relay, e);
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("relay thaw", relay[11:0], 12'(~oth[11:0]));
    cm(OP_QRY_CLR, 3'h1, 4'h0, 4'h0);
    cm(OP_QRY_DIS, 3'h2, 4'h3, 4'h0);
    cm(OP_QRY_DIS, 3'h2, 4'h4, 4'h0);
    cm(OP_QRY_DIS, 3'h3, 4'h5, 4'h0);
    rd("query", ADR_RES, 32'h5, '1);
    rd("count", ADR_STAT, 32'hC, 32'hFC);
    cm(OP_EN_LIST, 3'h2, 4'h3, 4'h0);
    repeat (2) @(posedge clk_sys);
    chk("relay en list", relay[14], 1'(~oth[14]));
    rd("en list on", ADR_CARD0 + 8'h4, 32'hFFF, 32'hFFF);
    e = relay;
    cm(OP_BIAS_MODE, 3'h4, 4'h0, 4'h0);
    cm(OP_DIS_CARD, 3'h4, 4'h0, 4'h0);
    ldp();
    chk("relay hold", relay[47:36], e[47:36]);
    rd("en off", ADR_CARD0 + 8'hC, 32'h0, 32'hFFF);
    cm(OP_BIAS_MODE, 3'h5, 4'h0, 4'h1);
    rd("err", ADR_STAT, 32'h1, 32'h1);
    wb(1'b1, ADR_STAT, 32'h1, 4'hF);
    rd("err clr", ADR_STAT, 32'h0, 32'h1);
    wb(1'b1, ADR_CMD, 32'h0000000D, 4'hF);
    rd("err op", ADR_STAT, 32'h1, 32'h1);
    wb(1'b1, ADR_STAT, 32'h1, 4'hF);
    cm(OP_CONFIG, 3'h7, 4'h0, 4'h0);
    cm(OP_BIAS_PORT, 3'h0, 4'h0, 4'h6);
    repeat (2) @(posedge clk_sys);
    chk("port auto", bport, 16'h6666);
    rd("auto", ADR_STAT, 32'h0, 32'h3);
    cm(OP_BIAS_PORT, 3'h1, 4'h0, 4'h3);
    rd("err auto", ADR_STAT, 32'h1, 32'h1);
    wb(1'b1, ADR_STAT, 32'h1, 4'hF);
    cm(OP_CONFIG, 3'h7, 4'h0, 4'h1);
    cm(OP_BIAS_PORT, 3'h2, 4'h0, 4'h1);
    repeat (2) @(posedge clk_sys);
    chk("port one", bport, 16'h6616);
    for (int r = 0; r < 2; r++) begin
      for (int s = 0; s < 3; s++) begin
        cm(OP_RULE, 3'h7, 4'h0, 4'(r));
        cm(OP_SEQ, 3'h7, 4'h0, 4'(s));
        rd("rule seq", ADR_CARD0 + 8'h8, {2'(s), 1'(r), 29'h0}, 32'hE0000000);
      end
    end
    cm(OP_RESET, 3'h7, 4'h0, 4'h0);
    repeat (2) @(posedge clk_sys);
    chk("mode rst", bmode, 4'h0);
    for (int c = 0; c < 4; c++) rd("card rst", ADR_CARD0 + 8'(4 * c), 32'h0A000FFF, 32'hFF000FFF);
    results();
  end
endmodule
